// File: core/lps_sequencer.sv
// device-side power and initialisation sequencer of the lcd driver
module lps_sequencer
#(
  parameter longint unsigned STAB_CYCLES   = lps_pkg::STAB_CYCLES,
  parameter longint unsigned SWRST_CYCLES  = lps_pkg::SWRST_CYCLES,
  parameter longint unsigned SETTLE_CYCLES = lps_pkg::SETTLE_CYCLES
)
(
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       hw_reset_n_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  output logic            busy_o,
  output logic            cmd_ignored_o,
  output logic            settings_reset_o,
  output logic            init_done_o,
  output logic            state_set_o,
  output logic            osc_on_o,
  output logic            booster_on_o,
  output logic            supply_stable_o,
  output logic            display_on_o,
  output logic            display_early_o
);
  import lps_pkg::*;

  lps_state_t state_q;
  logic       cmd_take;
  logic       phase_start;
  logic       phase_done;
  logic       settle_start;
  logic       settle_clear;
  logic       settle_done;
  logic       swrst_take;
  logic [TMR_W-1:0] phase_load;
  logic       ignored_q;
  logic       settings_reset_q;
  logic       init_done_q;
  logic       state_set_q;
  logic       osc_q;
  logic       booster_q;
  logic       stable_q;
  logic       display_q;
  logic       early_q;

  // command decode shared by the timers and the flag processes
  function automatic logic took_cmd(input logic       take,
                                    input logic [7:0] code_in,
                                    input logic [7:0] code);
    return take && (code_in == code);
  endfunction

  // a command is taken only in the run phase with the reset pin released
  assign cmd_take   = cmd_valid_i && hw_reset_n_i && (state_q == ST_RUN);
  assign swrst_take = took_cmd(cmd_take, cmd_byte_i, CMD_SW_RESET);

  // phase timer loads: stabilisation after release, wait after software reset
  assign phase_start = (state_q == ST_HOLD && hw_reset_n_i) || swrst_take;
  assign phase_load  = (state_q == ST_HOLD) ? TMR_W'(STAB_CYCLES) : TMR_W'(SWRST_CYCLES);

  lps_timer u_phase_tmr
  (
    .clock_i   (clock_i),
    .rstn_i    (rstn_i),
    .start_i   (phase_start),
    .clear_i   (!hw_reset_n_i),
    .load_i    (phase_load),
    .running_o (),
    .done_o    (phase_done)
  );

  // booster settle timer restarts on each booster-on, stops with the supply
  assign settle_start = took_cmd(cmd_take, cmd_byte_i, CMD_BOOSTER_ON);
  assign settle_clear = !hw_reset_n_i || swrst_take ||
                        took_cmd(cmd_take, cmd_byte_i, CMD_SLEEP_IN);

  lps_timer u_settle_tmr
  (
    .clock_i   (clock_i),
    .rstn_i    (rstn_i),
    .start_i   (settle_start),
    .clear_i   (settle_clear),
    .load_i    (TMR_W'(SETTLE_CYCLES)),
    .running_o (),
    .done_o    (settle_done)
  );

  // phase sequencing; a low reset pin always returns to hold
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= ST_HOLD;
    else if (!hw_reset_n_i)
      state_q <= ST_HOLD;
    else
    begin
      unique case (state_q)
        ST_HOLD:  state_q <= ST_STAB;
        ST_STAB:  state_q <= phase_done ? ST_RUN : ST_STAB;
        ST_RUN:   state_q <= swrst_take ? ST_SWRST : ST_RUN;
        ST_SWRST: state_q <= phase_done ? ST_RUN : ST_SWRST;
      endcase
    end
  end

  // commands arriving outside the run phase are dropped and reported
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ignored_q <= 1'b0;
    else
      ignored_q <= cmd_valid_i && !cmd_take;
  end

  // one-cycle pulse while internal settings are returned to defaults
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      settings_reset_q <= 1'b0;
    else
      settings_reset_q <= swrst_take || (state_q != ST_HOLD && !hw_reset_n_i);
  end

  // internal initialisation and internal state setting flags
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      init_done_q <= 1'b0;
      state_set_q <= 1'b0;
    end
    else if (!hw_reset_n_i || swrst_take)
    begin
      init_done_q <= 1'b0;
      state_set_q <= 1'b0;
    end
    else if (cmd_take)
    begin
      if (cmd_byte_i == CMD_INTERNAL_INIT)
        init_done_q <= 1'b1;
      if (cmd_byte_i == CMD_STATE_SET)
        state_set_q <= 1'b1;
    end
  end

  // oscillator follows sleep-out and sleep-in
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      osc_q <= 1'b0;
    else if (!hw_reset_n_i || swrst_take)
      osc_q <= 1'b0;
    else if (cmd_take && cmd_byte_i == CMD_SLEEP_OUT)
      osc_q <= 1'b1;
    else if (cmd_take && cmd_byte_i == CMD_SLEEP_IN)
      osc_q <= 1'b0;
  end

  // booster supply starts on booster-on, discharges on sleep-in
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      booster_q <= 1'b0;
    else if (settle_clear)
      booster_q <= 1'b0;
    else if (settle_start)
      booster_q <= 1'b1;
  end

  // supply counts as stable once the settle time has run out
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      stable_q <= 1'b0;
    else if (settle_clear || settle_start)
      stable_q <= 1'b0;
    else if (settle_done)
      stable_q <= 1'b1;
  end

  // display enable, with a sticky flag for switching on before the supply settled
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      display_q <= 1'b0;
      early_q   <= 1'b0;
    end
    else if (!hw_reset_n_i || swrst_take)
    begin
      display_q <= 1'b0;
      early_q   <= 1'b0;
    end
    else if (cmd_take)
    begin
      if (cmd_byte_i == CMD_DISPLAY_ON)
      begin
        display_q <= 1'b1;
        if (!stable_q)
          early_q <= 1'b1;
      end
      else if (cmd_byte_i == CMD_DISPLAY_OFF || cmd_byte_i == CMD_SLEEP_IN)
        display_q <= 1'b0;
    end
  end

  // outputs
  assign busy_o           = (state_q != ST_RUN);
  assign cmd_ignored_o    = ignored_q;
  assign settings_reset_o = settings_reset_q;
  assign init_done_o      = init_done_q;
  assign state_set_o      = state_set_q;
  assign osc_on_o         = osc_q;
  assign booster_on_o     = booster_q;
  assign supply_stable_o  = stable_q;
  assign display_on_o     = display_q;
  assign display_early_o  = early_q;

  // checks on the device behaviour
  property p_swrst_clears;
    @(posedge clock_i) disable iff (!rstn_i)
    swrst_take |=> busy_o && settings_reset_o && !osc_on_o && !booster_on_o && !init_done_o;
  endproperty
  a_swrst_clears: assert property (p_swrst_clears)
    else $error("software reset left state");

  property p_swrst_busy;
    @(posedge clock_i) disable iff (!rstn_i)
    swrst_take ##1 hw_reset_n_i [*8] |-> busy_o [*8];
  endproperty
  a_swrst_busy: assert property (p_swrst_busy) else $error("busy dropped after reset");

  property p_busy_drops;
    @(posedge clock_i) disable iff (!rstn_i)
    cmd_valid_i && busy_o |=> cmd_ignored_o && !$changed(init_done_o);
  endproperty
  a_busy_drops: assert property (p_busy_drops) else $error("busy command not dropped");

  property p_init;
    @(posedge clock_i) disable iff (!rstn_i)
    cmd_take && cmd_byte_i == CMD_INTERNAL_INIT |=> init_done_o;
  endproperty
  a_init: assert property (p_init) else $error("init command had no effect");

  property p_osc;
    @(posedge clock_i) disable iff (!rstn_i)
    cmd_take && cmd_byte_i == CMD_SLEEP_OUT |=> osc_on_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator not started");

  property p_boost;
    @(posedge clock_i) disable iff (!rstn_i)
    settle_start && !settle_clear |=> booster_on_o && !supply_stable_o;
  endproperty
  a_boost: assert property (p_boost) else $error("booster not started");

  property p_stable_needs_boost;
    @(posedge clock_i) disable iff (!rstn_i)
    $rose(supply_stable_o) |-> booster_on_o && $past(settle_done);
  endproperty
  a_stable_needs_boost: assert property (p_stable_needs_boost)
    else $error("stable without booster");

  c_swrst:   cover property (@(posedge clock_i) disable iff (!rstn_i) swrst_take);
  c_stable:  cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(supply_stable_o));
  c_display: cover property (@(posedge clock_i) disable iff (!rstn_i)
                             supply_stable_o && $rose(display_on_o));

endmodule

// File: core/lps_pkg.sv
// constants and types for the lcd driver power and initialisation sequencer
package lps_pkg;

  // clock and timing figures
  localparam longint unsigned CLK_FREQ_HZ     = 64'd50_000_000;
  localparam longint unsigned MS_PER_S        = 64'd1_000;
  localparam longint unsigned STAB_TIME_MS    = 64'd5;
  localparam longint unsigned SWRST_TIME_MS   = 64'd5;
  localparam longint unsigned BOOST_SETTLE_MS = 64'd40;

  // least times round up to whole cycles
  localparam longint unsigned STAB_CYCLES   = (STAB_TIME_MS * CLK_FREQ_HZ + MS_PER_S - 64'd1)
                                              / MS_PER_S;
  localparam longint unsigned SWRST_CYCLES  = (SWRST_TIME_MS * CLK_FREQ_HZ + MS_PER_S - 64'd1)
                                              / MS_PER_S;
  localparam longint unsigned SETTLE_CYCLES = (BOOST_SETTLE_MS * CLK_FREQ_HZ + MS_PER_S - 64'd1)
                                              / MS_PER_S;

  // timer width covers the longest wait
  localparam int TMR_W = 22;

  // command codes the sequencer acts upon
  localparam logic [7:0] CMD_SW_RESET      = 8'h01;
  localparam logic [7:0] CMD_BOOSTER_ON    = 8'h03;
  localparam logic [7:0] CMD_SLEEP_IN      = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT     = 8'h11;
  localparam logic [7:0] CMD_DISPLAY_OFF   = 8'h28;
  localparam logic [7:0] CMD_DISPLAY_ON    = 8'h29;
  localparam logic [7:0] CMD_STATE_SET     = 8'hb9;
  localparam logic [7:0] CMD_INTERNAL_INIT = 8'hc6;

  // sequencer phases, gray coded along hold, stabilise, run, software reset
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_STAB  = 2'b01,
    ST_RUN   = 2'b11,
    ST_SWRST = 2'b10
  } lps_state_t;

endpackage

// File: core/lps_timer.sv
// one-shot down counter used for the stabilisation and settle waits
module lps_timer
(
  input  wire logic                     clock_i,
  input  wire logic                     rstn_i,
  input  wire logic                     start_i,
  input  wire logic                     clear_i,
  input  wire logic [lps_pkg::TMR_W-1:0] load_i,
  output logic                          running_o,
  output logic                          done_o
);
  import lps_pkg::*;

  logic [TMR_W-1:0] count_q;
  logic             done_q;

  // count down; clear beats start, a load of zero behaves as one cycle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count_q <= '0;
      done_q  <= 1'b0;
    end
    else if (clear_i)
    begin
      count_q <= '0;
      done_q  <= 1'b0;
    end
    else if (start_i)
    begin
      count_q <= (load_i == '0) ? TMR_W'(1) : load_i;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= (count_q == TMR_W'(1)); // one-cycle pulse at expiry
      if (count_q != '0)
        count_q <= count_q - TMR_W'(1);
    end
  end

  assign running_o = (count_q != '0);
  assign done_o    = done_q;

endmodule

// File: dv/lps_host_model.sv
// host-side model that drives the reset pin and the command bytes
module lps_host_model
#(
  parameter int SETTLE = 50
)
(
  input  wire logic       clock_i,
  input  wire logic       busy_i,
  output logic            hw_reset_n_o,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import lps_pkg::*;

  int boost_age;  // cycles since booster-on was sent

  // power-on reset held from time zero
  initial
  begin
    hw_reset_n_o = 1'b0;
    cmd_valid_o  = 1'b0;
    cmd_byte_o   = 8'h00;
    boost_age    = 0;
  end

  // age of the last booster-on command
  always @(posedge clock_i)
  begin
    boost_age <= boost_age + 1;
  end

  // drive the reset pin just after a falling edge
  task automatic pin(input logic level);
    @(negedge clock_i);
    hw_reset_n_o = level;
  endtask

  // send one byte; rush skips the ready and settle waits on purpose
  task automatic send(input logic [7:0] code, input bit rush, output bit ok);
    int n = 0;
    while (!rush && n < 4000 && (busy_i !== 1'b0 ||
           (code == CMD_DISPLAY_ON && boost_age < SETTLE + 4)))
    begin
      @(negedge clock_i);
      n++;
    end
    ok = (n < 4000);
    @(negedge clock_i);
    cmd_valid_o = 1'b1;  // one whole byte per strobe
    cmd_byte_o  = code;
    if (code == CMD_BOOSTER_ON)
      boost_age = 0;
    @(negedge clock_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o  = ~code;  // released bus shows no stale value
  endtask
endmodule

// File: dv/lps_sequencer_tb_top.sv
// self-checking bench for the power and initialisation sequencer
module lps_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lps_pkg::*;

  localparam int STAB   = 20;
  localparam int SWRST  = 20;
  localparam int SETTLE = 50;

  typedef struct {logic [7:0] code; logic [5:0] flags;} lps_row_t;

  logic       clock_i;
  logic       rstn_i;
  logic       hw_reset_n;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       busy;
  logic       ignored;
  logic       sreset;
  logic       disp_early;
  wire  [5:0] flags;  // init, state, osc, boost, stable, display
  int         err_total;
  int         comparisons;
  int         ign_cnt;
  int         srst_cnt;
  int         n;

  // ordinary command stream with the flags it should leave
  lps_row_t rows [21] = '{'{8'hc6, 6'h20}, '{8'hb9, 6'h30}, '{8'hb6, 6'h30}, '{8'hb3, 6'h30},
    '{8'hb4, 6'h30}, '{8'hb5, 6'h30}, '{8'hbd, 6'h30}, '{8'hbe, 6'h30}, '{8'h11, 6'h38},
    '{8'hba, 6'h38}, '{8'h25, 6'h38}, '{8'hb7, 6'h38}, '{8'h03, 6'h3c}, '{8'h21, 6'h3c},
    '{8'h20, 6'h3c}, '{8'h30, 6'h3c}, '{8'h33, 6'h3c}, '{8'h37, 6'h3c}, '{8'h29, 6'h3f},
    '{8'h28, 6'h3e}, '{8'h10, 6'h30}};

  lps_host_model #(.SETTLE(SETTLE)) u_lps_host_model (.clock_i(clock_i), .busy_i(busy),
    .hw_reset_n_o(hw_reset_n), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte));

  lps_sequencer #(.STAB_CYCLES(STAB), .SWRST_CYCLES(SWRST), .SETTLE_CYCLES(SETTLE))
  u_lps_sequencer (.clock_i(clock_i), .rstn_i(rstn_i), .hw_reset_n_i(hw_reset_n),
    .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte), .busy_o(busy), .cmd_ignored_o(ignored),
    .settings_reset_o(sreset), .init_done_o(flags[5]), .state_set_o(flags[4]),
    .osc_on_o(flags[3]), .booster_on_o(flags[2]), .supply_stable_o(flags[1]),
    .display_on_o(flags[0]), .display_early_o(disp_early));

  // free-running clock
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // count one-cycle pulses where they are settled
  always @(negedge clock_i)
  begin
    ign_cnt  <= ign_cnt + int'(ignored === 1'b1);
    srst_cnt <= srst_cnt + int'(sreset === 1'b1);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one command through the host, a hung wait ends the run
  task automatic cmd(input logic [7:0] code, input bit rush);
    bit ok;
    u_lps_host_model.send(code, rush, ok);
    if (!ok)
    begin
      err_total++;
      conclude();
    end
  endtask

  // count cycles until the sequencer takes commands again
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (busy !== 1'b0 && cnt < 500)
    begin
      @(negedge clock_i);
      cnt++;
    end
    if (cnt >= 500)
    begin
      err_total++;
      conclude();
    end
  endtask

  initial
  begin
    rstn_i = 1'b0;
    err_total = 0;
    comparisons = 0;
    ign_cnt = 0;
    srst_cnt = 0;
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    rstn_i = 1'b1;
    check(16'(busy), 16'h1);
    check(16'(flags), 16'h0);
    // strobe while the pin is still low is refused
    cmd(CMD_SLEEP_OUT, 1'b1);
    @(negedge clock_i);
    check(16'(ign_cnt), 16'h1);
    check(16'(flags), 16'h0);
    // release the pin and time the stabilisation wait
    u_lps_host_model.pin(1'b1);
    wait_ready(n);
    check(16'(n >= STAB && n <= STAB + 4), 16'h1);
    foreach (rows[i])
    begin
      cmd(rows[i].code, 1'b0);
      @(negedge clock_i);
      check(16'(flags), 16'(rows[i].flags));
    end
    check(16'(ign_cnt), 16'h1);
    check(16'(disp_early), 16'h0);
    // software reset, then a refused byte during its wait
    cmd(CMD_SW_RESET, 1'b0);
    cmd(CMD_INTERNAL_INIT, 1'b1);
    @(negedge clock_i);
    check(16'(srst_cnt), 16'h1);
    check(16'(ign_cnt), 16'h2);
    check(16'(flags), 16'h0);
    wait_ready(n);
    check(16'(n >= SWRST - 6 && n <= SWRST + 4), 16'h1);
    // display-on sent too soon after booster-on is flagged
    cmd(CMD_BOOSTER_ON, 1'b0);
    cmd(CMD_DISPLAY_ON, 1'b1);
    @(negedge clock_i);
    check(16'(flags), 16'h05);
    check(16'(disp_early), 16'h1);
    // periodic refresh re-sends setup commands and leaves the supply alone
    cmd(CMD_STATE_SET, 1'b0);
    cmd(8'hbe, 1'b0);
    @(negedge clock_i);
    check(16'(flags), 16'h15);
    // the supply reports stable only once the settle time is up
    n = 0;
    while (flags[1] !== 1'b1 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 200)
    begin
      err_total++;
      conclude();
    end
    n = u_lps_host_model.boost_age;
    check(16'(n >= SETTLE && n <= SETTLE + 4), 16'h1);
    // power-down through the reset pin
    u_lps_host_model.pin(1'b0);
    repeat (2) @(negedge clock_i);
    check(16'(srst_cnt), 16'h2);
    check(16'({busy, disp_early, flags}), 16'h80);
    conclude();
  end
endmodule
